// ---- pwd_defines.svh ----
// Purpose: named constants for the peripheral write / dram read sequencer
// Assumes: one 125 MHz clock, bus clock made by an enable divider
// Notes:   times in ns as printed, cycle counts derived from them
`ifndef PWD_DEFINES_SVH
`define PWD_DEFINES_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define PWD_MCLK_NS        8
`define PWD_BCLK_NS        84
`define PWD_SCLK_NS        42
// least time: round up to whole mclk cycles
`define PWD_BCLK_CYC       ((`PWD_BCLK_NS + `PWD_MCLK_NS - 1) / `PWD_MCLK_NS)
// longest time: round down, no floor at one cycle
`define PWD_SCLK_CYC       (`PWD_SCLK_NS / `PWD_MCLK_NS)
`define PWD_WR_PULSE_BCLK  2
`define PWD_ADDR_W         16
`define PWD_DATA_W         16
`define PWD_DRAM_ADDR_W    10
`define PWD_DRAM_DATA_W    16
`define PWD_CNT_W          8
`define PWD_ONE_CNT        8'h01
`define PWD_ZERO_CNT       8'h00
`define PWD_ADDR_STEP      16'h0001
`define PWD_COL_STEP       10'h001

`endif

// ---- pwd_pkg.sv ----
// Purpose: types shared by the sequencer files
// Assumes: pwd_defines.svh included first
// Notes:   states are gray coded from idle up to the hold and latch states
`include "pwd_defines.svh"
package pwd_pkg;

  // ----------------------------------------------------------------------
  // write sequence states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    PWD_W_IDLE  = 3'b000,
    PWD_W_SEL   = 3'b001,
    PWD_W_STRB1 = 3'b011,
    PWD_W_STRB2 = 3'b010,
    PWD_W_HOLD  = 3'b110
  } pwd_wstate_t;

  // ----------------------------------------------------------------------
  // dram read states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    PWD_R_IDLE  = 3'b000,
    PWD_R_ROW   = 3'b001,
    PWD_R_RAS   = 3'b011,
    PWD_R_COL   = 3'b010,
    PWD_R_CAS   = 3'b110,
    PWD_R_LATCH = 3'b111,
    PWD_R_GAP   = 3'b101,
    PWD_R_END   = 3'b100
  } pwd_rstate_t;

  // peripheral write request
  typedef struct packed {
    logic                     start;
    logic [`PWD_ADDR_W-1:0]   addr;
    logic [`PWD_DATA_W-1:0]   data;
    logic                     wide;
  } pwd_wreq_t;

  // dram read request
  typedef struct packed {
    logic                         start;
    logic [`PWD_DRAM_ADDR_W-1:0]  row;
    logic [`PWD_DRAM_ADDR_W-1:0]  col;
    logic [`PWD_CNT_W-1:0]        beats;
  } pwd_rreq_t;

  // peripheral bus pins
  typedef struct packed {
    logic                     selN;
    logic                     wrN;
    logic [`PWD_ADDR_W-1:0]   addr;
    logic [`PWD_DATA_W-1:0]   data;
    logic                     dataOe;
    logic                     wideN;
  } pwd_pbus_t;

  // dram pins
  typedef struct packed {
    logic [`PWD_DRAM_ADDR_W-1:0]  addr;
    logic                         rasN;
    logic                         casN;
    logic                         rdN;
  } pwd_dram_t;

endpackage

// ---- pwd_bclk_div.sv ----
// Purpose: makes the one-cycle bus clock enable from mclk
// Assumes: divide ratio of at least one
// Notes:   pulse every DIV mclk cycles
`timescale 1ns/1ps
`include "pwd_defines.svh"
module pwd_bclk_div #(
  parameter int DIV = `PWD_BCLK_CYC
) (
  input  wire logic  mclk,
  input  wire logic  nrst,
  output logic       tick
);

  initial begin
    if (DIV < 1 || DIV > 256) $error("divide ratio out of counter range");
  end

  typedef struct packed {
    logic [`PWD_CNT_W-1:0] cnt;
    logic                  tick;
  } pwd_div_t;

  pwd_div_t st;
  pwd_div_t next_st;

  // ----------------------------------------------------------------------
  // free-running divider
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == `PWD_CNT_W'(DIV - 1)) begin
      next_st.cnt  = `PWD_ZERO_CNT;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + `PWD_ONE_CNT;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule

// ---- pwd_rd_sync.sv ----
// Purpose: delays the dram read strobe release by a few mclk cycles
// Assumes: strobes given in mclk domain
// Notes:   releases within one sclk period of both strobes going high
`timescale 1ns/1ps
`include "pwd_defines.svh"
module pwd_rd_sync #(
  parameter int LAG = `PWD_SCLK_CYC
) (
  input  wire logic  mclk,
  input  wire logic  nrst,
  input  wire logic  active,
  input  wire logic  strobesIdle,
  output logic       rdN
);

  initial begin
    if (LAG < 1) $error("release lag below one");
  end

  typedef struct packed {
    logic [`PWD_CNT_W-1:0] cnt;
    logic                  rdN;
  } pwd_rds_t;

  pwd_rds_t st;
  pwd_rds_t next_st;

  // ----------------------------------------------------------------------
  // hold strobe low while active, release lag cycles after idle
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (active) begin
      next_st.rdN = 1'b0;
      next_st.cnt = `PWD_ZERO_CNT;
    end else if (!st.rdN && strobesIdle) begin
      if (st.cnt >= `PWD_CNT_W'(LAG - 1)) begin
        next_st.rdN = 1'b1;
      end else begin
        next_st.cnt = st.cnt + `PWD_ONE_CNT;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st <= '{cnt: '0, rdN: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign rdN = st.rdN;

endmodule

// ---- pwd_seq.sv ----
// Purpose: peripheral bus write and dram page-mode read sequencer
// Assumes: write requests are one-cycle pulses, read requests held to a bus clock edge, both taken only while idle
// Notes:   all strobe steps fall on bus clock enables except read release
//
// Function
// - chip-select asserts one bus clock before the write strobe.
// - write strobe stays asserted for two bus clocks.
// - write data driven one bus clock after chip-select asserts.
// - write data held one bus clock after write strobe deasserts.
// - chip-select deasserts one bus clock after write strobe deasserts.
// - address steps one bus clock after strobe ends, if step enabled.
// - multi-beat dram reads become a series of page-mode cycles.
// - row address valid one bus clock before read strobe asserts.
// - row strobe asserts one bus clock after row address valid.
// - column address valid one bus clock after row strobe asserts.
// - column strobe asserts one bus clock after column address valid.
// - data latched and column advanced one bus clock after column strobe.
// - column strobe deasserts one bus clock after latch and advance.
// - column strobe high one bus clock between page accesses, row held.
`timescale 1ns/1ps
`include "pwd_defines.svh"
module pwd_seq #(
  parameter int BCLK_DIV = `PWD_BCLK_CYC,
  parameter int RD_LAG   = `PWD_SCLK_CYC
) (
  input  wire logic                         mclk,
  input  wire logic                         nrst,
  input  wire pwd_pkg::pwd_wreq_t           wreq,
  input  wire logic                         address_step_enable,
  input  wire pwd_pkg::pwd_rreq_t           rreq,
  input  wire logic [`PWD_DRAM_DATA_W-1:0]  dramData,
  output pwd_pkg::pwd_pbus_t                pbus,
  output pwd_pkg::pwd_dram_t                dram,
  output logic [`PWD_DRAM_DATA_W-1:0]       rdData,
  output logic                              rdValid,
  output logic                              wrBusy,
  output logic                              rdBusy
);

  initial begin
    if (BCLK_DIV < 1) $error("bus clock divide below one");
    if (BCLK_DIV > 127) $error("bus clock divide too large for run counter");
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    pwd_pkg::pwd_wstate_t            ws;
    pwd_pkg::pwd_rstate_t            rs;
    pwd_pkg::pwd_pbus_t              pbus;
    logic [`PWD_DRAM_ADDR_W-1:0]     dAddr;
    logic [`PWD_DRAM_ADDR_W-1:0]     col;
    logic                            rasN;
    logic                            casN;
    logic [`PWD_CNT_W-1:0]           beats;
    logic [`PWD_DRAM_DATA_W-1:0]     rdData;
    logic                            rdValid;
    logic                            rdActive;
    logic                            wPend;
    pwd_pkg::pwd_wreq_t              wHold;
    logic [`PWD_CNT_W-1:0]           wrLowRun;  // checker helper only
    logic                            wrBusy;
    logic                            rdBusy;
  } pwd_seq_st_t;

  pwd_seq_st_t st;
  pwd_seq_st_t next_st;
  logic        tick;
  logic        rdN;

  // bus clock enable
  pwd_bclk_div #(
    .DIV (BCLK_DIV)
  ) u_div (
    .mclk (mclk),
    .nrst (nrst),
    .tick (tick)
  );

  // read strobe release, mclk resolution, within one sclk
  pwd_rd_sync #(
    .LAG (RD_LAG)
  ) u_rd (
    .mclk        (mclk),
    .nrst        (nrst),
    .active      (next_st.rdActive),
    .strobesIdle (st.rasN && st.casN),
    .rdN         (rdN)
  );

  // ----------------------------------------------------------------------
  // next state: both sequences advance on bus clock enables
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rdValid = 1'b0;
    // strobe low run length, so checks need no long repetitions
    next_st.wrLowRun = st.pbus.wrN ? `PWD_ZERO_CNT : st.wrLowRun + `PWD_ONE_CNT;
    // a request is parked until the next bus clock edge
    if (wreq.start && st.ws == pwd_pkg::PWD_W_IDLE && !st.wPend) begin
      next_st.wPend = 1'b1;
      next_st.wHold = wreq;
    end
    if (tick) begin
      case (st.ws)
        pwd_pkg::PWD_W_IDLE: begin
          if (st.wPend) begin
            next_st.wPend      = 1'b0;
            next_st.pbus.selN  = 1'b0;
            next_st.pbus.addr  = st.wHold.addr;
            next_st.pbus.wideN = !st.wHold.wide;
            next_st.ws         = pwd_pkg::PWD_W_SEL;
          end
        end
        pwd_pkg::PWD_W_SEL: begin
          next_st.pbus.wrN    = 1'b0;
          next_st.pbus.data   = st.wHold.data;
          next_st.pbus.dataOe = 1'b1;
          next_st.ws          = pwd_pkg::PWD_W_STRB1;
        end
        pwd_pkg::PWD_W_STRB1: begin
          next_st.ws = pwd_pkg::PWD_W_STRB2;
        end
        pwd_pkg::PWD_W_STRB2: begin
          next_st.pbus.wrN = 1'b1;
          next_st.ws       = pwd_pkg::PWD_W_HOLD;
        end
        pwd_pkg::PWD_W_HOLD: begin
          next_st.pbus.selN   = 1'b1;
          next_st.pbus.dataOe = 1'b0;
          next_st.pbus.wideN  = 1'b1;
          if (address_step_enable) begin
            next_st.pbus.addr = st.pbus.addr + `PWD_ADDR_STEP;
          end
          next_st.ws = pwd_pkg::PWD_W_IDLE;
        end
        default: next_st.ws = pwd_pkg::PWD_W_IDLE;
      endcase
    end

    // dram read: request taken on a bus clock edge while idle
    if (tick) begin
      case (st.rs)
        pwd_pkg::PWD_R_IDLE: begin
          if (rreq.start && rreq.beats != `PWD_ZERO_CNT) begin
            next_st.dAddr    = rreq.row;
            next_st.col      = rreq.col;
            next_st.beats    = rreq.beats;
            next_st.rs       = pwd_pkg::PWD_R_ROW;
          end
        end
        pwd_pkg::PWD_R_ROW: begin
          next_st.rdActive = 1'b1;
          next_st.rasN     = 1'b0;
          next_st.rs       = pwd_pkg::PWD_R_RAS;
        end
        pwd_pkg::PWD_R_RAS: begin
          next_st.dAddr = st.col;
          next_st.rs    = pwd_pkg::PWD_R_COL;
        end
        pwd_pkg::PWD_R_COL, pwd_pkg::PWD_R_GAP: begin
          next_st.casN = 1'b0;
          next_st.rs   = pwd_pkg::PWD_R_CAS;
        end
        pwd_pkg::PWD_R_CAS: begin
          next_st.rdData  = dramData;
          next_st.rdValid = 1'b1;
          next_st.dAddr   = st.dAddr + `PWD_COL_STEP;
          next_st.beats   = st.beats - `PWD_ONE_CNT;
          next_st.rs      = pwd_pkg::PWD_R_LATCH;
        end
        pwd_pkg::PWD_R_LATCH: begin
          next_st.casN = 1'b1;
          if (st.beats != `PWD_ZERO_CNT) begin
            next_st.rs = pwd_pkg::PWD_R_GAP;
          end else begin
            next_st.rasN     = 1'b1;
            next_st.rdActive = 1'b0;
            next_st.rs       = pwd_pkg::PWD_R_END;
          end
        end
        pwd_pkg::PWD_R_END: begin
          next_st.rs = pwd_pkg::PWD_R_IDLE;
        end
        default: next_st.rs = pwd_pkg::PWD_R_IDLE;
      endcase
    end

    // busy flags kept in flip-flops so the outputs come straight from them
    next_st.wrBusy = next_st.wPend
      || (next_st.ws != pwd_pkg::PWD_W_IDLE);
    next_st.rdBusy = next_st.rdActive
      || (next_st.rs != pwd_pkg::PWD_R_IDLE);
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st           <= '0;
      st.ws        <= pwd_pkg::PWD_W_IDLE;
      st.rs        <= pwd_pkg::PWD_R_IDLE;
      st.pbus.selN <= 1'b1;
      st.pbus.wrN  <= 1'b1;
      st.pbus.wideN <= 1'b1;
      st.rasN      <= 1'b1;
      st.casN      <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops
  assign pbus      = st.pbus;
  assign dram.addr = st.dAddr;
  assign dram.rasN = st.rasN;
  assign dram.casN = st.casN;
  assign dram.rdN  = rdN;
  assign rdData    = st.rdData;
  assign rdValid   = st.rdValid;
  assign wrBusy    = st.wrBusy;
  assign rdBusy    = st.rdBusy;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  // select fell exactly one bus clock before the strobe
  sel_before_wr_a: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(pbus.wrN) |-> !pbus.selN && $past(pbus.selN, 12)
      && !$past(pbus.selN, 11))
    else $error("write strobe without prior select");
  // a counter instead of a long repetition keeps the checker cheap
  wr_width_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(pbus.wrN) |->
      st.wrLowRun == `PWD_CNT_W'(`PWD_WR_PULSE_BCLK * BCLK_DIV))
    else $error("write strobe width wrong");
  data_stable_a: assert property (@(posedge mclk) disable iff (!nrst)
    !pbus.wrN && !$past(pbus.wrN) |-> $stable(pbus.data) && pbus.dataOe)
    else $error("write data moved under the strobe");
  data_valid_a: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(pbus.wrN) |-> pbus.dataOe)
    else $error("data not driven with strobe");
  data_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(pbus.wrN) |-> ##10 pbus.dataOe ##1 !pbus.dataOe)
    else $error("data hold too short");
  sel_release_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(pbus.wrN) |-> !pbus.selN [*8] ##1 !pbus.selN ##[0:4] pbus.selN)
    else $error("select release late");
  // step enable is taken as it stood at the closing edge
  addr_fixed_a: assert property (@(posedge mclk) disable iff (!nrst)
    !$past(address_step_enable) && $rose(pbus.selN) |-> $stable(pbus.addr))
    else $error("address moved without step");
  addr_step_a: assert property (@(posedge mclk) disable iff (!nrst)
    $past(address_step_enable) && $rose(pbus.selN)
      |-> pbus.addr == $past(pbus.addr) + `PWD_ADDR_STEP)
    else $error("address did not step");
  addr_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    !pbus.selN && !$past(pbus.selN) |-> $stable(pbus.addr))
    else $error("address moved inside a write");

  // ----------------------------------------------------------------------
  // read side checks: windows assume the default bus divide of 11
  // ----------------------------------------------------------------------
  ras_after_row_a: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(dram.rasN) |-> !dram.rdN ##[1:2] !dram.rdN)
    else $error("row strobe without read strobe");
  col_addr_a: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(dram.rasN) |-> ##10 $stable(dram.addr) ##1 dram.addr == st.col)
    else $error("column address not on time");
  ras_to_cas_a: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(dram.rasN) |-> ##21 dram.casN ##1 !dram.casN)
    else $error("column strobe not on time");
  cas_width_a: assert property (@(posedge mclk) disable iff (!nrst)
    $fell(dram.casN) |-> ##21 !dram.casN ##1 dram.casN)
    else $error("column strobe width wrong");
  cas_gap_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(dram.casN) && !dram.rasN |-> dram.casN [*8] ##1 dram.casN)
    else $error("column gap too short");
  row_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(dram.casN) && st.beats != `PWD_ZERO_CNT |-> !dram.rasN)
    else $error("row strobe dropped mid page");
  beats_done_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(dram.rasN) |-> st.beats == `PWD_ZERO_CNT)
    else $error("page ended with beats left");
  rd_release_a: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(dram.rasN) |-> ##[1:5] dram.rdN)
    else $error("read strobe held too long");
  latch_data_a: assert property (@(posedge mclk) disable iff (!nrst)
    rdValid |-> rdData == $past(dramData))
    else $error("latched word differs from bus");
  latch_col_a: assert property (@(posedge mclk) disable iff (!nrst)
    rdValid |-> !dram.casN && dram.addr == $past(dram.addr) + `PWD_COL_STEP)
    else $error("latch without column step");

  wr_cycle_c: cover property (@(posedge mclk) $rose(pbus.selN));
  wr_step_c: cover property (@(posedge mclk)
    $rose(pbus.selN) && $past(address_step_enable));
  rd_multi_c: cover property (@(posedge mclk)
    rdValid && st.beats != `PWD_ZERO_CNT);
  rd_page_c: cover property (@(posedge mclk)
    $rose(dram.casN) && !dram.rasN);
  rd_done_c: cover property (@(posedge mclk) $rose(dram.rdN));

endmodule

// ---- pwd_far_side.sv ----
// Purpose: far-side model, one dram buffer and one peripheral device
// Assumes: pins come straight from pwd_seq, all in the mclk domain
// Notes:   dram word is {row[5:0], column}; a released bus keeps toggling
`timescale 1ns/1ps
`include "pwd_defines.svh"
module pwd_far_side (
  input  wire logic                         mclk,
  input  wire logic                         nrst,
  input  wire pwd_pkg::pwd_pbus_t           pbus,
  input  wire pwd_pkg::pwd_dram_t           dram,
  output logic [`PWD_DRAM_DATA_W-1:0]       dramData,
  output int                                wrCount,
  output logic [`PWD_DATA_W-1:0]            wrData
);
  // ----------------------------------------------------------------------
  // dram buffer and peripheral write capture
  // ----------------------------------------------------------------------
  logic [`PWD_DRAM_ADDR_W-1:0]  rowHeld;
  logic [`PWD_DRAM_ADDR_W-1:0]  colHeld;
  logic                         prevRas;
  logic                         prevCas;
  logic                         prevWr;

  // data only while the column strobe is low; otherwise a moving pattern
  // so a late latch still picks up the stale word by luck on every other cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rowHeld  <= 10'h000;
      colHeld  <= 10'h000;
      prevRas  <= 1'b1;
      prevCas  <= 1'b1;
      prevWr   <= 1'b1;
      dramData <= 16'ha5a5;
      wrCount  <= 0;
      wrData   <= 16'h0000;
    end else begin
      prevRas <= dram.rasN;
      prevCas <= dram.casN;
      prevWr  <= pbus.wrN;
      if (prevRas && !dram.rasN) rowHeld <= dram.addr;
      if (prevCas && !dram.casN) colHeld <= dram.addr;
      if (!dram.casN && !prevCas) dramData <= {rowHeld[5:0], colHeld};
      else dramData <= ~dramData;
      // device takes the word on the rising write strobe
      if (!prevWr && pbus.wrN) begin
        wrCount <= wrCount + 1;
        wrData  <= pbus.data;
      end
    end
  end
endmodule

// ---- pwd_seq_test.sv ----
// Purpose: self-checking bench for the write and dram read sequencer
// Assumes: default bus divide of 11 mclk cycles, read lag of 5
// Notes:   inputs change and outputs are sampled on the falling edge
`timescale 1ns/1ps
`include "pwd_defines.svh"
module pwd_seq_test;
  localparam int BT = 11;  // mclk cycles per bus tick
  logic                         mclk;
  logic                         nrst;
  pwd_pkg::pwd_wreq_t           wreq;
  logic                         address_step_enable;
  pwd_pkg::pwd_rreq_t           rreq;
  logic [`PWD_DRAM_DATA_W-1:0]  dramData;
  pwd_pkg::pwd_pbus_t           pbus;
  pwd_pkg::pwd_dram_t           dram;
  logic [`PWD_DRAM_DATA_W-1:0]  rdData;
  logic                         rdValid;
  logic                         wrBusy;
  logic                         rdBusy;
  int                           wrCount;
  logic [`PWD_DATA_W-1:0]       wrData;
  int                           fails;
  int                           comparisons;

  pwd_seq pwd_seq_i (.mclk(mclk), .nrst(nrst), .wreq(wreq),
    .address_step_enable(address_step_enable), .rreq(rreq),
    .dramData(dramData), .pbus(pbus), .dram(dram), .rdData(rdData),
    .rdValid(rdValid), .wrBusy(wrBusy), .rdBusy(rdBusy));
  pwd_far_side pwd_far_side_i (.mclk(mclk), .nrst(nrst), .pbus(pbus),
    .dram(dram), .dramData(dramData), .wrCount(wrCount), .wrData(wrData));

  // ----------------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------------
  task automatic check_int(input int got, input int exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic check_vec(input logic [15:0] got, input logic [15:0] exp,
                           input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic give_up(input string what);
    fails++;
    $display("CHECK FAILED t=%0t timeout in %s", $time, what);
    tally_and_finish();
  endtask

  // bounded wait for the read side to finish its closing bus tick
  task automatic wait_rd_idle();
    int n;
    for (n = 0; n < 4 * BT && rdBusy !== 1'b0; n++) @(negedge mclk);
    if (rdBusy !== 1'b0) give_up("read idle");
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  // one write; a second request lands mid-cycle and must be ignored
  task automatic do_write(input logic [15:0] a, input logic [15:0] d,
                          input logic step, input logic wide);
    int cyc, tSel, tWr, tWrUp, tUp, tOe, tOeDn, c0;
    logic [15:0] aEnd;
    tSel = -1; tWr = -1; tWrUp = -1; tUp = -1; tOe = -1; tOeDn = -1;
    c0 = wrCount;
    address_step_enable = step;
    wreq = '{start: 1'b1, addr: a, data: d, wide: wide};
    for (cyc = 1; cyc < 100 && tUp < 0; cyc++) begin
      @(negedge mclk);
      wreq.start = (cyc == 3);
      wreq.data  = ~d;
      if (tSel < 0 && !pbus.selN) tSel = cyc;
      if (tOe < 0 && pbus.dataOe) tOe = cyc;
      if (tOe >= 0 && tOeDn < 0 && !pbus.dataOe) tOeDn = cyc;
      if (tWr < 0 && !pbus.wrN) begin
        tWr = cyc;
        check_vec(pbus.data, d, "write data");
        check_vec(pbus.addr, a, "write address");
        check_vec({15'h0000, pbus.wideN}, {15'h0000, ~wide}, "wide");
        check_vec({15'h0000, wrBusy}, 16'h0001, "write busy");
      end
      if (tWr >= 0 && tWrUp < 0 && pbus.wrN) begin
        tWrUp = cyc;
        check_vec(pbus.data, d, "data after strobe");
      end
      if (tSel >= 0 && tUp < 0 && pbus.selN) begin
        tUp = cyc;
        aEnd = pbus.addr;
      end
    end
    if (tUp < 0) give_up("write");
    check_vec({15'h0000, wrBusy}, 16'h0000, "write idle");
    check_int(tWr - tSel, BT, "select to strobe");
    check_int(tWrUp - tWr, 2 * BT, "strobe width");
    check_int(tOe - tSel, BT, "select to data");
    check_int(tOeDn - tWrUp, BT, "data hold");
    check_int(tUp - tWrUp, BT, "strobe to deselect");
    check_vec(aEnd, a + {15'h0000, step}, "address step");
    check_int(wrCount - c0, 1, "one write only");
    check_vec(wrData, d, "device data");
    $display("write test done a=%h step=%0d", a, step);
  endtask

  // page-mode read of beats words from one row
  task automatic do_read(input logic [9:0] row, input logic [9:0] col,
                         input int beats);
    int cyc, tRow, tRas, tRd, tCol, tRasUp, tRdUp, nv, k;
    int casDn[$];
    int casUp[$];
    logic prevCas;
    tRow = -1; tRas = -1; tRd = -1; tCol = -1; tRasUp = -1; tRdUp = -1;
    nv = 0;
    prevCas = 1'b1;
    wait_rd_idle();
    rreq = '{start: 1'b1, row: row, col: col, beats: 8'(beats)};
    for (cyc = 1; cyc < 600 && tRdUp < 0; cyc++) begin
      @(negedge mclk);
      if (rdBusy === 1'b1) rreq.start = 1'b0;
      if (tRow < 0 && dram.addr === row) tRow = cyc;
      if (tRas < 0 && !dram.rasN) tRas = cyc;
      if (tRd < 0 && !dram.rdN) tRd = cyc;
      if (tRas >= 0 && tCol < 0 && dram.addr === col) tCol = cyc;
      if (prevCas && !dram.casN) casDn.push_back(cyc);
      if (!prevCas && dram.casN) casUp.push_back(cyc);
      prevCas = dram.casN;
      if (rdValid === 1'b1) begin
        check_vec(rdData, {row[5:0], 10'(col + nv)}, "read word");
        check_vec({6'h00, dram.addr}, {6'h00, 10'(col + nv + 1)},
                  "column step");
        check_int(cyc - casDn[nv], BT, "strobe to latch");
        nv++;
      end
      if (tRas >= 0 && tRasUp < 0 && dram.rasN) tRasUp = cyc;
      if (tRasUp >= 0 && tRdUp < 0 && dram.rdN) tRdUp = cyc;
    end
    if (tRdUp < 0) give_up("read");
    check_int(nv, beats, "beat count");
    check_int(tRd - tRow, BT, "row to read strobe");
    check_int(tRas - tRow, BT, "row to row strobe");
    check_int(tCol - tRas, BT, "row strobe to column");
    check_int(casDn[0] - tCol, BT, "column to strobe");
    for (k = 0; k < beats; k++) begin
      check_int(casUp[k] - casDn[k], 2 * BT, "strobe low time");
    end
    for (k = 0; k + 1 < beats; k++) begin
      check_int(casDn[k + 1] - casUp[k], BT, "page gap");
    end
    check_int(casUp[beats - 1], tRasUp, "strobes release together");
    check_int(tRdUp - tRasUp, 5, "read strobe release");
    $display("read test done row=%h beats=%0d", row, beats);
  endtask

  // a read request with zero beats starts nothing
  task automatic read_zero();
    int cyc;
    wait_rd_idle();
    rreq = '{start: 1'b1, row: 10'h155, col: 10'h020, beats: 8'h00};
    for (cyc = 0; cyc < 4 * BT; cyc++) begin
      @(negedge mclk);
      check_vec({14'h0000, rdBusy, dram.rasN}, 16'h0001, "zero beats");
    end
    rreq.start = 1'b0;
    $display("zero beat test done");
  endtask

  // ----------------------------------------------------------------------
  // clock, reset and main sequence
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial begin
    fails = 0;
    comparisons = 0;
    nrst = 1'b0;
    wreq = '0;
    rreq = '0;
    address_step_enable = 1'b0;
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    do_write(16'hffff, 16'h5a3c, 1'b1, 1'b1);
    do_write(16'h1234, 16'hc3a5, 1'b0, 1'b0);
    do_read(10'h2c5, 10'h011, 1);
    do_read(10'h13a, 10'h3fe, 3);
    read_zero();
    tally_and_finish();
  end
endmodule
